/* shared/aosrc_consts.vh */
// aosrc_consts.vh - constants of the aux out / converter / receiver register bank
// assumes: included by bare name from rtl files; definitions only
`ifndef AOSRC_CONSTS_VH
`define AOSRC_CONSTS_VH

// ****************************************
// register offsets (7-bit register address)
// ****************************************
`define AOSRC_OFS_AUX_REC      7'h07
`define AOSRC_OFS_DLY_MUTE     7'h08
`define AOSRC_OFS_RX_CFG1      7'h09
`define AOSRC_OFS_RX_CFG2      7'h0a

// ****************************************
// field positions
// ****************************************
`define AOSRC_AUX_SRC_HI       5
`define AOSRC_AUX_SRC_LO       4
`define AOSRC_AUX_SERIAL_WORD_SIZE_HI      3
`define AOSRC_AUX_SERIAL_WORD_SIZE_LO      2
`define AOSRC_AUX_FMT_HI       1
`define AOSRC_AUX_FMT_LO       0
`define AOSRC_DLY_MUTE_BIT     7
`define AOSRC_DLY_HI           6
`define AOSRC_CFG1_FALLBACK    7
`define AOSRC_CFG1_RATIO_HI    6
`define AOSRC_CFG1_RATIO_LO    5
`define AOSRC_CFG1_DEEMPH      4
`define AOSRC_CFG1_ERR_HI      3
`define AOSRC_CFG1_ERR_LO      2
`define AOSRC_CFG1_LOCK_HI     1
`define AOSRC_CFG1_LOCK_LO     0
`define AOSRC_CFG2_HMUTE       7
`define AOSRC_CFG2_REF_EN      6
`define AOSRC_CFG2_REF_HI      5
`define AOSRC_CFG2_REF_LO      4
`define AOSRC_CFG2_NONAUD      1
`define AOSRC_CFG2_VALID       0

// ****************************************
// reserved codes and reset values
// ****************************************
`define AOSRC_FMT_RSVD         2'h2
`define AOSRC_RATIO_RSVD       2'h3
`define AOSRC_ERR_RSVD         2'h3
`define AOSRC_RST_2B           2'h0
`define AOSRC_RST_1B           1'h0
`define AOSRC_RST_DLY          7'h00
// bits in one control port byte
`define AOSRC_BYTE_BITS        4'h8

`endif

/* rtl/aosrc_reg_bank.v */
// aosrc_reg_bank.v - two-wire control port slave and config register bank
// assumes: scl/sda come from pins (open-drain, pulled up outside);
// receiver status inputs come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "aosrc_consts.vh"

// Behaviour
// - aux record clock source: slave, pll, int1, int2
// - aux word size code: 24/20/18/16 bits
// - aux framing: left, i2s, right; 10 reserved
// - converter mute bit ramps output to silence
// - seven-bit fir delay, 0..127 input samples
// - unlocked receiver clock: pll or internal one
// - receiver clock ratio 128/256/512, 11 reserved
// - auto de-emphasis from channel status when set
// - error response: none, hold, zero sample
// - lock loss: none, hold, zeros, soft mute
// - receiver config one bit layout at 0x09
// - receiver config two bit layout at 0x0a
// - receiver mute bit hard-mutes receiver audio
// - pll reference: chosen port frame clock
// - validity block keeps receiver data out
// - nonaudio block; compressed payload always blocked
module aosrc_reg_bank #(
    parameter [6:0] DEV_ADDR = 7'h10  // bus address, arbitrary default
) (
    // clock and reset
    input  wire       clock,
    input  wire       nrst,
    // control port pins
    input  wire       scl_in,
    input  wire       sda_in,
    output reg        sda_out,
    output reg        sda_oe,
    // receiver status, same clock
    input  wire       pll_locked,
    input  wire       rx_parity_err,
    input  wire       rx_invalid,
    input  wire       rx_nonaudio,
    input  wire       rx_iec61937,
    input  wire       rx_emph_flag,
    // aux record port fields
    output reg  [1:0] port_timing_source_r,
    output reg  [1:0] serial_word_size_r,
    output reg  [1:0] serial_framing_format_r,
    // converter fields
    output reg        converter_soft_silence_r,
    output reg  [6:0] fir_extra_delay_r,
    // receiver fields
    output reg  [1:0] receiver_clock_ratio_r,
    output reg        receiver_hard_silence_r,
    output reg        port_reference_enable_r,
    output reg  [1:0] reference_port_choice_r,
    // receiver derived controls
    output reg        rx_clk_internal_r,
    output reg        deemph_active_r,
    output reg  [1:0] rx_sample_action_r,
    output reg        rx_src_block_r
);

    // ****************************************
    // states of the port slave
    // ****************************************
    localparam [2:0] ST_IDLE = 3'h0;  // waiting for start
    localparam [2:0] ST_ADDR = 3'h1;  // receiving address byte
    localparam [2:0] ST_AACK = 3'h2;  // acking address
    localparam [2:0] ST_RX   = 3'h3;  // receiving pointer or data
    localparam [2:0] ST_DACK = 3'h4;  // acking data byte
    localparam [2:0] ST_TX   = 3'h5;  // sending data byte
    localparam [2:0] ST_MACK = 3'h6;  // master ack slot

    // ****************************************
    // declarations
    // ****************************************
    reg        scl_s1_r;            // sync stage one
    reg        scl_s2_r;            // sync stage two
    reg        scl_d_r;             // delayed for edges
    reg        sda_s1_r;            // sync stage one
    reg        sda_s2_r;            // sync stage two
    reg        sda_d_r;             // delayed for edges
    reg  [2:0] state_r;             // slave state
    reg  [3:0] bit_cnt_r;           // bits shifted
    reg  [7:0] shift_r;             // shift register
    reg        rw_r;                // read transfer flag
    reg        ptr_phase_r;         // next byte is pointer
    reg        mack_r;              // master acked
    reg  [6:0] ptr_r;               // register pointer
    reg        fallback_r;          // unlocked clock fallback
    reg        auto_emph_r;         // auto emphasis undo
    reg  [1:0] err_resp_r;          // error response
    reg  [1:0] lock_resp_r;         // lock loss response
    reg        payload_block_r;     // nonaudio flag block
    reg        invalid_block_r;     // invalid flag block
    reg  [7:0] rd_data;             // read mux
    wire       scl_rise;            // scl rising
    wire       scl_fall;            // scl falling
    wire       start_c;             // start condition
    wire       stop_c;              // stop condition
    wire       wr_en;               // register write strobe

    assign scl_rise = scl_s2_r & ~scl_d_r;
    assign scl_fall = ~scl_s2_r & scl_d_r;
    assign start_c  = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
    assign stop_c   = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;
    assign wr_en    = (state_r == ST_RX) && scl_fall
                      && (bit_cnt_r == `AOSRC_BYTE_BITS) && !ptr_phase_r;

    // ****************************************
    // pin synchronisers
    // ****************************************
    // two flops before any logic, then an edge copy
    always @(posedge clock) begin
        if (!nrst) begin
            scl_s1_r <= 1'b1;
            scl_s2_r <= 1'b1;
            scl_d_r  <= 1'b1;
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
            sda_d_r  <= 1'b1;
        end else begin
            scl_s1_r <= scl_in;
            scl_s2_r <= scl_s1_r;
            scl_d_r  <= scl_s2_r;
            sda_s1_r <= sda_in;
            sda_s2_r <= sda_s1_r;
            sda_d_r  <= sda_s2_r;
        end
    end

    // ****************************************
    // read mux
    // ****************************************
    // reserved bits zero
    always @* begin
        case (ptr_r)
            `AOSRC_OFS_AUX_REC: rd_data = {2'h0, port_timing_source_r,
                                           serial_word_size_r, serial_framing_format_r};
            `AOSRC_OFS_DLY_MUTE: rd_data = {converter_soft_silence_r, fir_extra_delay_r};
            `AOSRC_OFS_RX_CFG1: rd_data = {fallback_r, receiver_clock_ratio_r,
                                           auto_emph_r, err_resp_r, lock_resp_r};
            `AOSRC_OFS_RX_CFG2: rd_data = {receiver_hard_silence_r, port_reference_enable_r,
                                           reference_port_choice_r, 2'h0,
                                           payload_block_r, invalid_block_r};
            default: rd_data = 8'h00;  // unmapped reads zero
        endcase
    end

    // ****************************************
    // port slave state machine
    // ****************************************
    // samples sda on scl rise, changes sda after scl fall
    always @(posedge clock) begin
        if (!nrst) begin
            state_r     <= ST_IDLE;
            bit_cnt_r   <= 4'h0;
            shift_r     <= 8'h00;
            rw_r        <= 1'b0;
            ptr_phase_r <= 1'b0;
            mack_r      <= 1'b0;
            ptr_r       <= 7'h00;
            sda_out     <= 1'b0;
            sda_oe      <= 1'b0;
        end else if (start_c) begin
            // start or repeated start
            state_r   <= ST_ADDR;
            bit_cnt_r <= 4'h0;
            sda_oe    <= 1'b0;
        end else if (stop_c) begin
            state_r <= ST_IDLE;
            sda_oe  <= 1'b0;
        end else begin
            sda_out <= 1'b0;
            case (state_r)
                ST_ADDR, ST_RX: begin
                    if (scl_rise && bit_cnt_r != `AOSRC_BYTE_BITS) begin
                        shift_r   <= {shift_r[6:0], sda_s2_r};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end else if (scl_fall && bit_cnt_r == `AOSRC_BYTE_BITS) begin
                        bit_cnt_r <= 4'h0;
                        if (state_r == ST_ADDR) begin
                            // ack only our own address
                            if (shift_r[7:1] == DEV_ADDR) begin
                                rw_r    <= shift_r[0];
                                sda_oe  <= 1'b1;
                                state_r <= ST_AACK;
                            end else begin
                                state_r <= ST_IDLE;
                            end
                        end else begin
                            // pointer byte, or data with auto increment
                            if (ptr_phase_r)
                                ptr_r <= shift_r[6:0];
                            else
                                ptr_r <= ptr_r + 7'h01;
                            ptr_phase_r <= 1'b0;
                            sda_oe      <= 1'b1;
                            state_r     <= ST_DACK;
                        end
                    end
                end
                ST_AACK: begin
                    if (scl_fall) begin
                        if (rw_r) begin
                            shift_r <= {rd_data[6:0], 1'b0};
                            sda_oe  <= ~rd_data[7];
                            ptr_r   <= ptr_r + 7'h01;
                            state_r <= ST_TX;
                        end else begin
                            sda_oe      <= 1'b0;
                            ptr_phase_r <= 1'b1;
                            state_r     <= ST_RX;
                        end
                    end
                end
                ST_DACK: begin
                    if (scl_fall) begin
                        sda_oe  <= 1'b0;
                        state_r <= ST_RX;
                    end
                end
                ST_TX: begin
                    if (scl_rise) begin
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt_r == `AOSRC_BYTE_BITS) begin
                            bit_cnt_r <= 4'h0;
                            sda_oe    <= 1'b0;
                            state_r   <= ST_MACK;
                        end else begin
                            sda_oe  <= ~shift_r[7];
                            shift_r <= {shift_r[6:0], 1'b0};
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        mack_r <= ~sda_s2_r;
                    end else if (scl_fall) begin
                        if (mack_r) begin
                            shift_r <= {rd_data[6:0], 1'b0};
                            sda_oe  <= ~rd_data[7];
                            ptr_r   <= ptr_r + 7'h01;
                            state_r <= ST_TX;
                        end else begin
                            state_r <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                    sda_oe  <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // register writes
    // ****************************************
    always @(posedge clock) begin
        if (!nrst) begin
            port_timing_source_r     <= `AOSRC_RST_2B;
            serial_word_size_r       <= `AOSRC_RST_2B;
            serial_framing_format_r  <= `AOSRC_RST_2B;
            converter_soft_silence_r <= `AOSRC_RST_1B;
            fir_extra_delay_r        <= `AOSRC_RST_DLY;
            fallback_r               <= `AOSRC_RST_1B;
            receiver_clock_ratio_r   <= `AOSRC_RST_2B;
            auto_emph_r              <= `AOSRC_RST_1B;
            err_resp_r               <= `AOSRC_RST_2B;
            lock_resp_r              <= `AOSRC_RST_2B;
            receiver_hard_silence_r  <= `AOSRC_RST_1B;
            port_reference_enable_r  <= `AOSRC_RST_1B;
            reference_port_choice_r  <= `AOSRC_RST_2B;
            payload_block_r          <= `AOSRC_RST_1B;
            invalid_block_r          <= `AOSRC_RST_1B;
        end else if (wr_en) begin
            case (ptr_r)
                `AOSRC_OFS_AUX_REC: begin
                    port_timing_source_r <= shift_r[`AOSRC_AUX_SRC_HI:`AOSRC_AUX_SRC_LO];
                    serial_word_size_r   <= shift_r[`AOSRC_AUX_SERIAL_WORD_SIZE_HI:`AOSRC_AUX_SERIAL_WORD_SIZE_LO];
                    if (shift_r[`AOSRC_AUX_FMT_HI:`AOSRC_AUX_FMT_LO] != `AOSRC_FMT_RSVD)
                        serial_framing_format_r <= shift_r[`AOSRC_AUX_FMT_HI:`AOSRC_AUX_FMT_LO];
                end
                `AOSRC_OFS_DLY_MUTE: begin
                    converter_soft_silence_r <= shift_r[`AOSRC_DLY_MUTE_BIT];
                    fir_extra_delay_r        <= shift_r[`AOSRC_DLY_HI:0];
                end
                `AOSRC_OFS_RX_CFG1: begin
                    fallback_r  <= shift_r[`AOSRC_CFG1_FALLBACK];
                    auto_emph_r <= shift_r[`AOSRC_CFG1_DEEMPH];
                    lock_resp_r <= shift_r[`AOSRC_CFG1_LOCK_HI:`AOSRC_CFG1_LOCK_LO];
                    if (shift_r[`AOSRC_CFG1_RATIO_HI:`AOSRC_CFG1_RATIO_LO] != `AOSRC_RATIO_RSVD)
                        receiver_clock_ratio_r <=
                            shift_r[`AOSRC_CFG1_RATIO_HI:`AOSRC_CFG1_RATIO_LO];
                    if (shift_r[`AOSRC_CFG1_ERR_HI:`AOSRC_CFG1_ERR_LO] != `AOSRC_ERR_RSVD)
                        err_resp_r <= shift_r[`AOSRC_CFG1_ERR_HI:`AOSRC_CFG1_ERR_LO];
                end
                `AOSRC_OFS_RX_CFG2: begin
                    receiver_hard_silence_r <= shift_r[`AOSRC_CFG2_HMUTE];
                    port_reference_enable_r <= shift_r[`AOSRC_CFG2_REF_EN];
                    reference_port_choice_r <= shift_r[`AOSRC_CFG2_REF_HI:`AOSRC_CFG2_REF_LO];
                    payload_block_r         <= shift_r[`AOSRC_CFG2_NONAUD];
                    invalid_block_r         <= shift_r[`AOSRC_CFG2_VALID];
                end
                default: begin
                    // unmapped writes dropped
                end
            endcase
        end
    end

    // ****************************************
    // receiver derived controls
    // ****************************************
    // action codes: 0 pass, 1 hold, 2 zero, 3 soft mute
    always @(posedge clock) begin
        if (!nrst) begin
            rx_clk_internal_r  <= 1'b0;
            deemph_active_r    <= 1'b0;
            rx_sample_action_r <= 2'h0;
            rx_src_block_r     <= 1'b0;
        end else begin
            rx_clk_internal_r <= ~pll_locked & fallback_r;
            deemph_active_r   <= auto_emph_r & rx_emph_flag;
            if (!pll_locked)
                rx_sample_action_r <= lock_resp_r;
            else if (rx_parity_err)
                rx_sample_action_r <= err_resp_r;
            else
                rx_sample_action_r <= 2'h0;
            rx_src_block_r <= (invalid_block_r & rx_invalid)
                            | (payload_block_r & rx_nonaudio)
                            | rx_iec61937;
        end
    end

endmodule
`default_nettype wire

/* tb/aosrc_reg_bank_assertions.sv */
// port checks of the aux out / converter / receiver register bank
// assumes: bound into aosrc_reg_bank; one clock, sync active-low reset
`timescale 1ns/1ps
`default_nettype none
module aosrc_chk (
    // clock and reset
    input wire logic       clock,
    input wire logic       nrst,
    // pin drive
    input wire logic       sda_oe,
    // receiver status
    input wire logic       pll_locked,
    input wire logic       rx_parity_err,
    input wire logic       rx_invalid,
    input wire logic       rx_nonaudio,
    input wire logic       rx_iec61937,
    input wire logic       rx_emph_flag,
    // fields and derived controls
    input wire logic [1:0] port_timing_source_r,
    input wire logic [1:0] serial_framing_format_r,
    input wire logic [6:0] fir_extra_delay_r,
    input wire logic       converter_soft_silence_r,
    input wire logic [1:0] receiver_clock_ratio_r,
    input wire logic       rx_clk_internal_r,
    input wire logic       deemph_active_r,
    input wire logic [1:0] rx_sample_action_r,
    input wire logic       rx_src_block_r
);
    // ****************************************
    // properties, all on the one clock
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    // reset holds fields and pin release at zero
    a_reset_clears: assert property (disable iff (1'b0)
        !nrst |=> !sda_oe && {port_timing_source_r, serial_framing_format_r,
        fir_extra_delay_r, converter_soft_silence_r, receiver_clock_ratio_r} == 14'h0000)
        else $error("fields not cleared by reset");
    a_framing_no_rsvd: assert property (serial_framing_format_r != 2'h2)
        else $error("reserved framing code taken");
    a_ratio_no_rsvd: assert property (receiver_clock_ratio_r != 2'h3)
        else $error("reserved clock ratio taken");
    a_locked_pll_clock: assert property (pll_locked |=> !rx_clk_internal_r)
        else $error("internal clock chosen while locked");
    a_emph_needs_flag: assert property (!rx_emph_flag |=> !deemph_active_r)
        else $error("de-emphasis without channel flag");
    a_action_clean_pass: assert property (
        pll_locked && !rx_parity_err |=> rx_sample_action_r == 2'h0)
        else $error("sample action without cause");
    a_action_err_codes: assert property (
        pll_locked && rx_parity_err |=> rx_sample_action_r != 2'h3)
        else $error("soft mute on parity error");
    a_payload_blocked: assert property (rx_iec61937 |=> rx_src_block_r)
        else $error("compressed payload let through");
    a_data_open: assert property (
        !rx_invalid && !rx_nonaudio && !rx_iec61937 |=> !rx_src_block_r)
        else $error("clean data blocked");
endmodule
// attach to every register bank instance
bind aosrc_reg_bank aosrc_chk u_chk (.*);
`default_nettype wire

/* tb/aosrc_host_model.sv */
// two-wire host controller model driving the register bank control port
// assumes: sda is open drain with pull-up resolved by the bench
`timescale 1ns/1ps
`default_nettype none
module aosrc_host #(
    parameter [6:0] DEV_ADDR = 7'h10  // must match the device address
) (
    // clock and resolved data line
    input  wire logic clock,
    input  wire logic sda,
    // driven lines
    output var logic  scl,
    output var logic  sda_low
);
    // idle: clock high, data released
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // half period of ten system clocks, above the eight minimum
    task hp;
        repeat (10) @(negedge clock);
    endtask
    // start or repeated start: data falls while clock high
    task start_c;
        repeat (2) @(negedge clock);
        sda_low = 1'b0;
        hp;
        scl = 1'b1;
        hp;
        sda_low = 1'b1;
        hp;
        scl = 1'b0;
    endtask
    // stop: data rises while clock high
    task stop_c;
        repeat (2) @(negedge clock);
        sda_low = 1'b1;
        hp;
        scl = 1'b1;
        hp;
        sda_low = 1'b0;
        hp;
    endtask
    // eight bits msb first then ninth slot released, sampled at end of high
    task xbyte(input logic [7:0] b, output logic [7:0] rd, output logic ack);
        for (int i = 0; i < 9; i++) begin
            repeat (2) @(negedge clock);
            sda_low = (i < 8) ? ~b[7 - i] : 1'b0;
            hp;
            scl = 1'b1;
            hp;
            if (i < 8) rd = {rd[6:0], sda};
            else ack = sda;
            scl = 1'b0;
        end
    endtask
    // pointer then one data byte
    task write_reg(input logic [6:0] ptr, input logic [7:0] d, output logic nak);
        logic [7:0] rd;
        logic       a0, a1, a2;
        start_c;
        xbyte({DEV_ADDR, 1'b0}, rd, a0);
        xbyte({1'b0, ptr}, rd, a1);
        xbyte(d, rd, a2);
        stop_c;
        nak = a0 | a1 | a2;
    endtask
    // pointer write, repeated start, one byte read and nacked
    task read_reg(input logic [6:0] ptr, output logic [7:0] d, output logic nak);
        logic [7:0] rd;
        logic       a0, a1, a2, a3;
        start_c;
        xbyte({DEV_ADDR, 1'b0}, rd, a0);
        xbyte({1'b0, ptr}, rd, a1);
        start_c;
        xbyte({DEV_ADDR, 1'b1}, rd, a2);
        xbyte(8'hff, d, a3);
        stop_c;
        nak = a0 | a1 | a2;
    endtask
endmodule
`default_nettype wire

/* tb/test_aux_out_src_receiver_config.sv */
// self-checking bench of the register bank over the two-wire port
// assumes: aosrc_host model; receiver status driven at random
`timescale 1ns/1ps
`default_nettype none
module test_aux_out_src_receiver_config;
    // clock, reset, pins, receiver status
    logic       clock, nrst, scl_in, host_low, sda_out, sda_oe;
    logic       pll_locked, rx_parity_err, rx_invalid, rx_nonaudio, rx_iec61937, rx_emph_flag;
    // register fields and derived controls
    logic [1:0] port_timing_source_r, serial_word_size_r, serial_framing_format_r;
    logic [1:0] receiver_clock_ratio_r, reference_port_choice_r, rx_sample_action_r;
    logic       converter_soft_silence_r, receiver_hard_silence_r, port_reference_enable_r;
    logic       rx_clk_internal_r, deemph_active_r, rx_src_block_r;
    logic [6:0] fir_extra_delay_r;
    // bench state
    logic [7:0] exp_q [0:3];        // shadow of 0x07..0x0a
    logic [7:0] lfsr, wr, d;
    logic [1:0] idx;
    logic       nak;
    logic [9:0] corner [0:3] = '{10'h1ff, 10'h100, 10'h2ff, 10'h0fe};  // idx and data
    int         fail_count, samples_checked, cyc;
    // open-drain line with pull-up
    wire logic  sda_in = (sda_oe || host_low) ? 1'b0 : 1'b1;
    // ****************************************
    // design and host
    // ****************************************
    aosrc_reg_bank u_dut (.*);
    aosrc_host u_host (.clock(clock), .sda(sda_in), .scl(scl_in), .sda_low(host_low));
    // grouped views of outputs
    wire logic [7:0] aux_seen = {2'h0, port_timing_source_r, serial_word_size_r,
                                 serial_framing_format_r};
    wire logic [7:0] cfg2_seen = {receiver_hard_silence_r, port_reference_enable_r,
                                  reference_port_choice_r, 4'h0};
    wire logic [7:0] der_seen = {3'h0, rx_clk_internal_r, deemph_active_r,
                                 rx_sample_action_r, rx_src_block_r};
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [7:0] apply(input logic [1:0] i, input logic [7:0] o, w);
        logic [7:0] v;
        v = w;
        if (i == 2'h0) v[7:6] = 2'h0;
        if (i == 2'h0 && w[1:0] == 2'h2) v[1:0] = o[1:0];
        if (i == 2'h2 && w[6:5] == 2'h3) v[6:5] = o[6:5];
        if (i == 2'h2 && w[3:2] == 2'h3) v[3:2] = o[3:2];
        if (i == 2'h3) v[3:2] = 2'h0;
        return v;
    endfunction
    function automatic logic [7:0] derived();
        logic [1:0] a;
        a = !pll_locked ? exp_q[2][1:0] : (rx_parity_err ? exp_q[2][3:2] : 2'h0);
        return {3'h0, !pll_locked & exp_q[2][7], exp_q[2][4] & rx_emph_flag, a,
                rx_iec61937 | (exp_q[3][1] & rx_nonaudio) | (exp_q[3][0] & rx_invalid)};
    endfunction
    task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task chk_all;
        check("aux port", aux_seen, exp_q[0]);
        check("delay mute", {converter_soft_silence_r, fir_extra_delay_r}, exp_q[1]);
        check("ratio", {6'h0, receiver_clock_ratio_r}, {6'h0, exp_q[2][6:5]});
        check("cfg two", cfg2_seen, {exp_q[3][7:4], 4'h0});
        check("derived", der_seen, derived());
    endtask
    task rd_chk(input logic [6:0] ptr, input logic [7:0] exp);
        u_host.read_reg(ptr, d, nak);
        check("read ack", {7'h0, nak}, 8'h00);
        check("readback", d, exp);
        check("sda drive", {7'h0, sda_out}, 8'h00);
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // ****************************************
    // clock and hang guard
    // ****************************************
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            fail_count++;
            end_of_test;
        end
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {nrst, pll_locked, rx_parity_err, rx_invalid, rx_nonaudio, rx_iec61937} = 6'h00;
        rx_emph_flag = 1'b0;
        fail_count = 0;
        samples_checked = 0;
        lfsr = 8'h27;
        exp_q = '{8'h00, 8'h00, 8'h00, 8'h00};
        repeat (10) @(negedge clock);
        nrst = 1'b1;
        repeat (5) @(negedge clock);
        chk_all;
        for (int i = 0; i < 4; i++) rd_chk(7'h07 + 7'(i), 8'h00);
        // foreign address is left unanswered
        u_host.start_c;
        u_host.xbyte(8'h42, d, nak);
        u_host.stop_c;
        check("foreign ack", {7'h0, nak}, 8'h01);
        u_host.write_reg(7'h0b, 8'hff, nak);
        rd_chk(7'h0b, 8'h00);
        // corner values first, then random writes and status
        for (int i = 0; i < 28; i++) begin
            lfsr = lfsr_next(lfsr);
            idx = (i < 4) ? corner[i][9:8] : lfsr[1:0];
            lfsr = lfsr_next(lfsr);
            wr = (i < 4) ? corner[i][7:0] : lfsr;
            u_host.write_reg(7'h07 + {5'h00, idx}, wr, nak);
            check("write ack", {7'h0, nak}, 8'h00);
            exp_q[idx] = apply(idx, exp_q[idx], wr);
            lfsr = lfsr_next(lfsr);
            {pll_locked, rx_parity_err, rx_invalid, rx_nonaudio, rx_iec61937} = lfsr[4:0];
            rx_emph_flag = lfsr[5];
            repeat (2) @(negedge clock);
            chk_all;
            rd_chk(7'h07 + {5'h00, idx}, exp_q[idx]);
        end
        nrst = 1'b0;
        repeat (3) @(negedge clock);
        nrst = 1'b1;
        exp_q = '{8'h00, 8'h00, 8'h00, 8'h00};
        repeat (2) @(negedge clock);
        chk_all;
        end_of_test;
    end
endmodule
`default_nettype wire
